/* File: rtl/psc_pkg.sv */
// shared constants, types and helpers of the preamp serial control port
package psc_pkg;

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int WORD_WIDTH = 16;
  localparam int GAIN_WIDTH = 7;
  localparam int GAIN_LSB = 0;
  localparam int USER_LSB = 10;
  localparam int USER_COUNT = 4;
  localparam int THRESH_BIT = 14;
  localparam int SERVO_BIT = 15;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // gain codes
  // ----------------------------------------------------------------
  localparam logic [6:0] GAIN_UNITY = 7'h00;
  localparam logic [6:0] GAIN_MIN_DB = 7'h0A;
  localparam logic [6:0] GAIN_MAX_DB = 7'h41;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int ZC_TIMEOUT_MS = 16;
  localparam int ZC_TIMEOUT_CYCLES = (CLK_FREQ_HZ / 1000) * ZC_TIMEOUT_MS;
  localparam int ZC_TIMER_WIDTH = 21;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  localparam int SYNC_COUNT = 9;
  localparam logic [8:0] SYNC_RESET = 9'h100;

  typedef enum logic [1:0] {
    PSC_IDLE = 2'b01,
    PSC_WAIT = 2'b10
  } psc_zc_state_type;

  // codes below the lowest step give unity, codes above the top step clamp
  function automatic logic [6:0] psc_gain_decode(input logic [6:0] code);
    logic [6:0] res;
    res = code;
    if (code < GAIN_MIN_DB) begin
      res = GAIN_UNITY;
    end else if (code > GAIN_MAX_DB) begin
      res = GAIN_MAX_DB;
    end
    return res;
  endfunction

endpackage

/* File: rtl/psc_link_if.sv */
// internal carrier between the port core, the shifter and the gain sequencer
interface psc_link_if;
  logic csHigh;
  logic csRise;
  logic sclkRise;
  logic sclkFall;
  logic sdiBit;
  logic [15:0] shiftWord;
  logic sdoBit;
  logic latchPulse;
  logic [15:0] ctrlWord;
  logic unityForce;
  logic zcEnable;
  logic zcDetect;
  logic [6:0] gainApplied;

  modport shifter (
    input csHigh, csRise, sclkRise, sclkFall, sdiBit,
    output shiftWord, sdoBit, latchPulse
  );

  modport gainSeq (
    input ctrlWord, latchPulse, unityForce, zcEnable, zcDetect,
    output gainApplied
  );
endinterface

/* File: rtl/psc_shift_port.sv */
// serial shift register, read-back output stage and word latch strobe
module psc_shift_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link to the core
  psc_link_if.shifter link
);
  import psc_pkg::*;

  // ----------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.shiftWord <= WORD_RESET;
    end else if (!link.csHigh && link.sclkRise) begin
      link.shiftWord <= {link.shiftWord[WORD_WIDTH-2:0], link.sdiBit};
    end
  end

  // ----------------------------------------------------------------
  // output stage: last bit of the register, moved on falling edges and on every cycle while deselected
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.sdoBit <= 1'b0;
    end else if (link.csHigh || link.sclkFall) begin
      link.sdoBit <= link.shiftWord[WORD_WIDTH-1];
    end
  end

  // ----------------------------------------------------------------
  // latch strobe on deselect
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.latchPulse <= 1'b0;
    end else begin
      link.latchPulse <= link.csRise;
    end
  end

endmodule

/* File: rtl/psc_gain_seq.sv */
// gain change sequencer: unity override, zero crossing wait and timeout
module psc_gain_seq #(
  parameter int ZC_TIMEOUT = psc_pkg::ZC_TIMEOUT_CYCLES,
  parameter int TIMER_WIDTH = psc_pkg::ZC_TIMER_WIDTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link to the core
  psc_link_if.gainSeq link
);
  import psc_pkg::*;

  localparam logic [TIMER_WIDTH-1:0] TIMER_LAST = TIMER_WIDTH'(ZC_TIMEOUT - 1);

  psc_zc_state_type state_r;
  logic [TIMER_WIDTH-1:0] timer_r;
  logic [6:0] target;
  logic wantChange;
  logic timerDone;
  logic applyNow;

  always_comb begin
    target = psc_gain_decode(link.ctrlWord[GAIN_LSB +: GAIN_WIDTH]);
    wantChange = target != link.gainApplied;
    timerDone = timer_r == TIMER_LAST;
    applyNow = !link.unityForce && wantChange &&
               (!link.zcEnable || (state_r == PSC_WAIT && (link.zcDetect || timerDone)));
  end

  // ----------------------------------------------------------------
  // applied gain
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.gainApplied <= GAIN_UNITY;
    end else if (link.unityForce) begin
      link.gainApplied <= GAIN_UNITY;
    end else if (applyNow) begin
      link.gainApplied <= target;
    end
  end

  // ----------------------------------------------------------------
  // wait state and timeout timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PSC_IDLE;
    end else begin
      case (state_r)
        PSC_IDLE: begin
          if (!link.unityForce && wantChange && link.zcEnable) begin
            state_r <= PSC_WAIT;
          end
        end
        PSC_WAIT: begin
          if (link.unityForce || applyNow || !wantChange) begin
            state_r <= PSC_IDLE;
          end
        end
        default: begin
          state_r <= PSC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= '0;
    end else if (state_r != PSC_WAIT || link.latchPulse) begin
      timer_r <= '0;
    end else if (!timerDone) begin
      timer_r <= timer_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_zc_hold;
    @(posedge core_clk) disable iff (!rst_n)
      state_r == PSC_WAIT && link.zcEnable && !link.zcDetect && !timerDone && !link.unityForce
      |=> $stable(link.gainApplied);
  endproperty
  a_zc_hold: assert property (p_zc_hold) else $error("gain moved before zero crossing");

  property p_zc_timeout;
    @(posedge core_clk) disable iff (!rst_n)
      state_r == PSC_WAIT && timerDone && !link.unityForce
      |=> state_r == PSC_IDLE && link.gainApplied == $past(target);
  endproperty
  a_zc_timeout: assert property (p_zc_timeout) else $error("timeout did not apply gain");

endmodule

/* File: rtl/psc_serial_port.sv */
// top of the preamp serial control port: pin sampling, control latch, outputs
module psc_serial_port #(
  parameter int ZC_TIMEOUT = psc_pkg::ZC_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic chipSelect_n,
  input wire logic sclk,
  input wire logic portDataIn,
  output logic portDataOut,
  output logic portDataOutEn_n,
  // control pins
  input wire logic unityGainForce,
  input wire logic zeroCrossEnable,
  input wire logic servoEnable_n,
  // analog side reports
  input wire logic zeroCrossDetect,
  input wire logic levelOverHigh,
  input wire logic levelOverLow,
  // settings out
  output logic [psc_pkg::GAIN_WIDTH-1:0] gainCode,
  output logic servoDisable,
  output logic overloadFlag,
  output logic [psc_pkg::USER_COUNT-1:0] userOut
);
  import psc_pkg::*;

  psc_link_if link ();

  logic [SYNC_COUNT-1:0] pinRaw;
  logic [SYNC_COUNT-1:0] syncMeta_r;
  logic [SYNC_COUNT-1:0] sync_r;
  logic csSync;
  logic sclkSync;
  logic sclkPrev_r;
  logic csPrev_r;
  logic [WORD_WIDTH-1:0] ctrlWord_r;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pinRaw = {chipSelect_n, sclk, portDataIn, unityGainForce, zeroCrossEnable,
                   servoEnable_n, zeroCrossDetect, levelOverHigh, levelOverLow};

  generate
    for (genvar i = 0; i < SYNC_COUNT; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          syncMeta_r[i] <= SYNC_RESET[i];
          sync_r[i] <= SYNC_RESET[i];
        end else begin
          syncMeta_r[i] <= pinRaw[i];
          sync_r[i] <= syncMeta_r[i];
        end
      end
    end
  endgenerate

  assign csSync = sync_r[8];
  assign sclkSync = sync_r[7];

  // ----------------------------------------------------------------
  // edge detection of select and serial clock
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkPrev_r <= 1'b0;
      csPrev_r <= 1'b1;
    end else begin
      sclkPrev_r <= sclkSync;
      csPrev_r <= csSync;
    end
  end

  always_comb begin
    link.csHigh = csSync;
    link.csRise = csSync && !csPrev_r;
    link.sclkRise = sclkSync && !sclkPrev_r && !csSync;
    link.sclkFall = !sclkSync && sclkPrev_r && !csSync;
    link.sdiBit = sync_r[6];
    link.unityForce = sync_r[5];
    link.zcEnable = sync_r[4];
    link.zcDetect = sync_r[2];
    link.ctrlWord = ctrlWord_r;
  end

  // ----------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------
  psc_shift_port u_shift (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .link(link)
  );

  psc_gain_seq #(
    .ZC_TIMEOUT(ZC_TIMEOUT),
    .TIMER_WIDTH(ZC_TIMER_WIDTH)
  ) u_gain (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .link(link)
  );

  // ----------------------------------------------------------------
  // control register, loaded as a whole on each latch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlWord_r <= WORD_RESET;
    end else if (link.latchPulse) begin
      ctrlWord_r <= link.shiftWord;
    end
  end

  // ----------------------------------------------------------------
  // serial output pin
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      portDataOut <= 1'b0;
      portDataOutEn_n <= 1'b1;
    end else begin
      portDataOut <= csSync ? 1'b0 : link.sdoBit;
      portDataOutEn_n <= csSync;
    end
  end

  // ----------------------------------------------------------------
  // settings outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gainCode <= GAIN_UNITY;
    end else begin
      gainCode <= link.gainApplied;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      servoDisable <= 1'b0;
      userOut <= '0;
    end else begin
      servoDisable <= ctrlWord_r[SERVO_BIT] | sync_r[3];
      userOut <= ctrlWord_r[USER_LSB +: USER_COUNT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overloadFlag <= 1'b0;
    end else begin
      overloadFlag <= ctrlWord_r[THRESH_BIT] ? sync_r[0] : sync_r[1];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_selected_rise;
    !csSync && link.sclkRise;
  endsequence

  sequence s_selected_fall;
    !csSync && link.sclkFall;
  endsequence

  property p_latch_word;
    @(posedge core_clk) disable iff (!rst_n)
      link.csRise ##1 link.latchPulse |=> ctrlWord_r == $past(link.shiftWord);
  endproperty
  a_latch_word: assert property (p_latch_word) else $error("word not latched on select rise");

  property p_ignore_idle;
    @(posedge core_clk) disable iff (!rst_n)
      csSync |=> $stable(link.shiftWord);
  endproperty
  a_ignore_idle: assert property (p_ignore_idle) else $error("shift register moved while deselected");

  property p_release_out;
    @(posedge core_clk) disable iff (!rst_n)
      csSync |=> portDataOutEn_n;
  endproperty
  a_release_out: assert property (p_release_out) else $error("serial output driven while deselected");

  property p_drive_out;
    @(posedge core_clk) disable iff (!rst_n)
      !csSync [*2] |-> !portDataOutEn_n;
  endproperty
  a_drive_out: assert property (p_drive_out) else $error("serial output not driven while selected");

  property p_sample_in;
    @(posedge core_clk) disable iff (!rst_n)
      s_selected_rise |=> link.shiftWord == {$past(link.shiftWord[WORD_WIDTH-2:0]), $past(link.sdiBit)};
  endproperty
  a_sample_in: assert property (p_sample_in) else $error("input bit not shifted on rising clock");

  property p_shift_out;
    @(posedge core_clk) disable iff (!rst_n)
      s_selected_fall ##1 !csSync |=> portDataOut == $past(link.shiftWord[WORD_WIDTH-1], 2);
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("output bit not last stage after falling clock");

  property p_unity_force;
    @(posedge core_clk) disable iff (!rst_n)
      link.unityForce [*3] |-> gainCode == GAIN_UNITY;
  endproperty
  a_unity_force: assert property (p_unity_force) else $error("unity pin did not force unity gain");

  property p_unity_accept;
    @(posedge core_clk) disable iff (!rst_n)
      link.unityForce && link.latchPulse |=> ctrlWord_r == $past(link.shiftWord);
  endproperty
  a_unity_accept: assert property (p_unity_accept) else $error("word refused under unity pin");

  property p_immediate;
    @(posedge core_clk) disable iff (!rst_n)
      (!link.zcEnable && !link.unityForce) [*3]
      |-> gainCode == psc_gain_decode($past(ctrlWord_r[GAIN_LSB +: GAIN_WIDTH], 2));
  endproperty
  a_immediate: assert property (p_immediate) else $error("gain not applied at once");

  property p_servo;
    @(posedge core_clk) disable iff (!rst_n)
      ##1 servoDisable == ($past(ctrlWord_r[SERVO_BIT]) | $past(sync_r[3]));
  endproperty
  a_servo: assert property (p_servo) else $error("servo disable wrong");

  property p_overload;
    @(posedge core_clk) disable iff (!rst_n)
      ##1 overloadFlag == ($past(ctrlWord_r[THRESH_BIT]) ? $past(sync_r[0]) : $past(sync_r[1]));
  endproperty
  a_overload: assert property (p_overload) else $error("overload flag does not follow selected level");

  property p_together;
    @(posedge core_clk) disable iff (!rst_n)
      link.latchPulse ##1 1'b1 |=> userOut == $past(link.shiftWord[USER_LSB +: USER_COUNT], 2) &&
        servoDisable == ($past(link.shiftWord[SERVO_BIT], 2) | $past(sync_r[3]));
  endproperty
  a_together: assert property (p_together) else $error("latched settings not updated together");

  property p_word_hold;
    @(posedge core_clk) disable iff (!rst_n)
      !link.latchPulse |=> $stable(ctrlWord_r);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("control word moved without a latch");

  property p_out_idle;
    @(posedge core_clk) disable iff (!rst_n)
      csSync |=> !portDataOut;
  endproperty
  a_out_idle: assert property (p_out_idle) else $error("serial output not parked while deselected");

  sequence s_select_fall;
    $fell(csSync);
  endsequence

  property p_first_out;
    @(posedge core_clk) disable iff (!rst_n)
      s_select_fall |=> portDataOut == $past(link.shiftWord[WORD_WIDTH-1]);
  endproperty
  a_first_out: assert property (p_first_out) else $error("first output bit not last shift stage");

  property p_latch_rise;
    @(posedge core_clk) disable iff (!rst_n)
      link.latchPulse |-> $past(csSync) && !$past(csSync, 2);
  endproperty
  a_latch_rise: assert property (p_latch_rise) else $error("latch strobe without select rise");

  property p_gain_range;
    @(posedge core_clk) disable iff (!rst_n)
      gainCode == GAIN_UNITY || (gainCode >= GAIN_MIN_DB && gainCode <= GAIN_MAX_DB);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain code outside unity and step range");

  property p_user_hold;
    @(posedge core_clk) disable iff (!rst_n)
      !link.latchPulse ##1 1'b1 |=> $stable(userOut);
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("user outputs moved without a latch");

  property p_gain_source;
    @(posedge core_clk) disable iff (!rst_n)
      !$stable(gainCode) |-> gainCode == GAIN_UNITY ||
        gainCode == psc_gain_decode($past(ctrlWord_r[GAIN_LSB +: GAIN_WIDTH], 2));
  endproperty
  a_gain_source: assert property (p_gain_source) else $error("gain not from word or unity");

endmodule

/* File: testbench/psc_host_model.sv */
// host serial master model driving the select, clock and data pins
module psc_host_model (
  // clock of the bench
  input wire logic core_clk,
  // serial pins
  output logic chipSelect_n,
  output logic sclk,
  output logic portDataIn,
  input wire logic sdoLine
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // idle pin levels
  // ----------------------------------------------------------------
  initial begin
    chipSelect_n = 1'h1;
    sclk = 1'h0;
    portDataIn = 1'h0;
  end

  // ----------------------------------------------------------------
  // one framed transfer, msb first, 40 ns per clock phase
  // ----------------------------------------------------------------
  task automatic frame(input logic [31:0] data, input int nbits, output logic [31:0] got);
    got = 32'h0;
    @(negedge core_clk);
    chipSelect_n = 1'h0;
    for (int i = nbits - 1; i >= 0; i--) begin
      portDataIn = data[i];
      repeat (4) @(negedge core_clk);
      // returned bit taken at the rising edge, as a host would
      got[i] = sdoLine;
      sclk = 1'h1;
      repeat (4) @(negedge core_clk);
      sclk = 1'h0;
    end
    repeat (6) @(negedge core_clk);
    chipSelect_n = 1'h1;
    // released data line shows no stale value
    portDataIn = ~portDataIn;
  endtask

  // clock and data activity while deselected
  task automatic noise();
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(negedge core_clk);
      sclk = ~sclk;
      portDataIn = ~portDataIn;
    end
  endtask
endmodule

/* File: testbench/psc_serial_port_tb.sv */
// self-checking bench of the preamp serial control port
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t ns: got %0h expected %0h", $time, (g), (e)); end end
module psc_serial_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import psc_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk, rst_n, chipSelect_n, sclk, portDataIn, portDataOut, portDataOutEn_n;
  logic unityGainForce, zeroCrossEnable, servoEnable_n, zeroCrossDetect, levelOverHigh, levelOverLow;
  logic [6:0] gainCode;
  logic servoDisable, overloadFlag;
  logic [3:0] userOut;
  wire sdoLine;
  int n_fail = 0;
  int checks_done = 0;
  logic [15:0] rb, w1, w2, w3, w4;
  logic [31:0] g32;
  logic [6:0] gIn [5] = '{7'h0A, 7'h41, 7'h05, 7'h46, 7'h00};
  logic [6:0] gExp [5] = '{7'h0A, 7'h41, 7'h00, 7'h41, 7'h00};

  assign sdoLine = portDataOutEn_n ? 1'bz : portDataOut;

  // ----------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------
  psc_serial_port #(.ZC_TIMEOUT(50)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .chipSelect_n(chipSelect_n), .sclk(sclk),
    .portDataIn(portDataIn), .portDataOut(portDataOut), .portDataOutEn_n(portDataOutEn_n),
    .unityGainForce(unityGainForce), .zeroCrossEnable(zeroCrossEnable), .servoEnable_n(servoEnable_n),
    .zeroCrossDetect(zeroCrossDetect), .levelOverHigh(levelOverHigh), .levelOverLow(levelOverLow),
    .gainCode(gainCode), .servoDisable(servoDisable), .overloadFlag(overloadFlag), .userOut(userOut)
  );

  psc_host_model host (
    .core_clk(core_clk), .chipSelect_n(chipSelect_n), .sclk(sclk), .portDataIn(portDataIn), .sdoLine(sdoLine)
  );

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] mk(input logic [6:0] gn, input logic [3:0] u, input logic t, input logic s);
    return {s, t, u, 3'h0, gn};
  endfunction

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] w, output logic [15:0] back);
    host.frame({16'h0, w}, 16, g32);
    back = g32[15:0];
    repeat (8) @(negedge core_clk);
  endtask

  task automatic wait_gain(input logic [6:0] e, input int lo, input int hi);
    int n;
    n = 0;
    while (gainCode !== e && n < hi) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(gainCode, e)
    `CHK(n >= lo, 1'h1)
    if (n >= hi) begin
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    {unityGainForce, zeroCrossEnable, servoEnable_n, zeroCrossDetect, levelOverHigh, levelOverLow} = 6'h00;
    repeat (20) @(negedge core_clk);
    rst_n = 1'h1;
    repeat (3) @(negedge core_clk);
    `CHK(portDataOutEn_n, 1'h1)
    `CHK(portDataOut, 1'h0)
    `CHK(gainCode, GAIN_UNITY)
    w1 = mk(7'h1E, 4'hA, 1'h0, 1'h0);
    wr(w1, rb);
    `CHK(rb, WORD_RESET)
    `CHK({gainCode, userOut, servoDisable}, {7'h1E, 4'hA, 1'h0})
    `CHK(portDataOutEn_n, 1'h1)
    host.noise();
    w2 = mk(7'h20, 4'h5, 1'h0, 1'h0);
    wr(w2, rb);
    `CHK(rb, w1)
    w3 = mk(7'h2A, 4'h3, 1'h0, 1'h0);
    w4 = mk(7'h33, 4'hC, 1'h0, 1'h0);
    host.frame({w3, w4}, 32, g32);
    repeat (8) @(negedge core_clk);
    `CHK(g32, {w2, w3})
    `CHK({gainCode, userOut}, {7'h33, 4'hC})
    for (int i = 0; i < 5; i++) begin
      wr(mk(gIn[i], 4'h0, 1'h0, 1'h0), rb);
      `CHK(gainCode, gExp[i])
    end
    wr(mk(7'h28, 4'h1, 1'h0, 1'h0), rb);
    unityGainForce = 1'h1;
    wait_gain(GAIN_UNITY, 0, 8);
    wr(mk(7'h32, 4'h6, 1'h0, 1'h0), rb);
    `CHK({gainCode, userOut}, {GAIN_UNITY, 4'h6})
    unityGainForce = 1'h0;
    wait_gain(7'h32, 0, 10);
    zeroCrossEnable = 1'h1;
    wr(mk(7'h14, 4'h6, 1'h0, 1'h0), rb);
    repeat (10) @(negedge core_clk);
    `CHK(gainCode, 7'h32)
    zeroCrossDetect = 1'h1;
    wait_gain(7'h14, 0, 8);
    zeroCrossDetect = 1'h0;
    wr(mk(7'h19, 4'h6, 1'h0, 1'h0), rb);
    wait_gain(7'h19, 30, 80);
    zeroCrossEnable = 1'h0;
    wr(mk(7'h19, 4'h0, 1'h0, 1'h1), rb);
    `CHK(servoDisable, 1'h1)
    wr(mk(7'h19, 4'h0, 1'h0, 1'h0), rb);
    `CHK(servoDisable, 1'h0)
    servoEnable_n = 1'h1;
    repeat (6) @(negedge core_clk);
    `CHK(servoDisable, 1'h1)
    levelOverHigh = 1'h1;
    repeat (6) @(negedge core_clk);
    `CHK(overloadFlag, 1'h1)
    {levelOverHigh, levelOverLow} = 2'h1;
    repeat (6) @(negedge core_clk);
    `CHK(overloadFlag, 1'h0)
    wr(mk(7'h19, 4'h0, 1'h1, 1'h0), rb);
    `CHK(overloadFlag, 1'h1)
    levelOverLow = 1'h0;
    repeat (6) @(negedge core_clk);
    `CHK(overloadFlag, 1'h0)
    // reset in mid-run: outputs return to their reset levels, shift register cleared
    rst_n = 1'h0;
    repeat (2) @(negedge core_clk);
    `CHK({gainCode, userOut, servoDisable, overloadFlag, portDataOutEn_n}, {GAIN_UNITY, 4'h0, 3'h1})
    rst_n = 1'h1;
    repeat (3) @(negedge core_clk);
    wr(mk(7'h2C, 4'h9, 1'h0, 1'h0), rb);
    `CHK({rb, gainCode, userOut, servoDisable}, {WORD_RESET, 7'h2C, 4'h9, 1'h1})
    end_sim();
  end
endmodule
